// ### rtl/video_gain_level_pkg.sv
package video_gain_level_pkg;

    // ---------------------------------------------------------------
    // Subaddress map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_U_GAIN_LOW = 8'h5b;
    localparam logic [7:0] ADDR_V_GAIN_LOW = 8'h5c;
    localparam logic [7:0] ADDR_U_MSB_BLACK = 8'h5d;
    localparam logic [7:0] ADDR_V_MSB_BLANK = 8'h5e;
    localparam logic [7:0] ADDR_XCOLOR_VBLANK = 8'h5f;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int GAIN_TOP_BIT = 7;
    localparam int RTC_ENABLE_BIT = 6;
    localparam int LEVEL_MSB = 5;
    localparam int XCOLOR_HI_BIT = 7;
    localparam int XCOLOR_LO_BIT = 6;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RESET_U_GAIN_LOW = 8'h7d;
    localparam logic [7:0] RESET_V_GAIN_LOW = 8'haf;
    localparam logic [7:0] RESET_U_MSB_BLACK = 8'h33;
    localparam logic [7:0] RESET_V_MSB_BLANK = 8'h35;
    localparam logic [7:0] RESET_XCOLOR_VBLANK = 8'h35;
    localparam logic [5:0] BLANK_LEVEL_RESET = 6'h35;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ---------------------------------------------------------------
    // Gain scaling and reference codes
    // ---------------------------------------------------------------
    localparam int GAIN_FRAC_BITS = 7;
    localparam logic [8:0] U_NOMINAL_92 = 9'h076;
    localparam logic [8:0] U_NOMINAL_100 = 9'h07d;
    localparam logic [8:0] U_NOMINAL_SECAM = 9'h06a;
    localparam logic [8:0] V_NOMINAL_92 = 9'h0a5;
    localparam logic [8:0] V_NOMINAL_100 = 9'h0af;
    localparam logic [8:0] V_NOMINAL_SECAM = 9'h081;

    typedef enum logic [1:0] {
        XCOLOR_OFF = 2'b00,
        XCOLOR_FILTER1 = 2'b01,
        XCOLOR_FILTER2 = 2'b10,
        XCOLOR_FILTER3 = 2'b11
    } crosscolor_mode_t;

endpackage : video_gain_level_pkg

// ### rtl/video_encoder_gain_level_regs.sv
module video_encoder_gain_level_regs
    import video_gain_level_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic lineStart,
    input wire logic realtimeFieldParity,
    input wire logic realtimePhaseReset,
    input wire logic signed [7:0] uChromaIn,
    input wire logic signed [7:0] vChromaIn,
    output logic signed [9:0] uContrib,
    output logic signed [9:0] vContrib,
    output logic [5:0] blackLevelCode,
    output logic [5:0] blankingLevelCode,
    output logic [5:0] verticalBlankingLevelCode,
    output crosscolor_mode_t crossColorSel,
    output logic fieldParityOut,
    output logic subcarrierPhaseResetPulse
);

    // ---------------------------------------------------------------
    // Host-visible registers
    // ---------------------------------------------------------------
    logic [7:0] uGainLow_q;
    logic [7:0] vGainLow_q;
    logic [7:0] uMsbBlack_q;
    logic [7:0] vMsbBlank_q;
    logic [7:0] xcolorVblank_q;

    function automatic logic [8:0] join_gain(input logic [7:0] msbReg, input logic [7:0] lowReg);
        return {msbReg[GAIN_TOP_BIT], lowReg};
    endfunction : join_gain

    function automatic logic signed [9:0] scale_chroma(input logic signed [7:0] sample,
                                                       input logic [8:0] gain);
        logic signed [16:0] prod;
        prod = sample * $signed(gain);
        return prod[GAIN_FRAC_BITS +: 10];
    endfunction : scale_chroma

    // One decoder feeds both the write strobes and the read mux, so the two
    // paths can never disagree about which subaddresses exist.
    function automatic logic [4:0] decode_addr(input logic [7:0] addr);
        logic [4:0] sel;
        sel = 5'h00;
        if (addr == ADDR_U_GAIN_LOW) begin
            sel = 5'h01;
        end else if (addr == ADDR_V_GAIN_LOW) begin
            sel = 5'h02;
        end else if (addr == ADDR_U_MSB_BLACK) begin
            sel = 5'h04;
        end else if (addr == ADDR_V_MSB_BLANK) begin
            sel = 5'h08;
        end else if (addr == ADDR_XCOLOR_VBLANK) begin
            sel = 5'h10;
        end
        return sel;
    endfunction : decode_addr

    logic [4:0] addrSel;
    assign addrSel = decode_addr(regAddr);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            uGainLow_q <= RESET_U_GAIN_LOW;
            vGainLow_q <= RESET_V_GAIN_LOW;
            uMsbBlack_q <= RESET_U_MSB_BLACK;
            vMsbBlank_q <= RESET_V_MSB_BLANK;
            xcolorVblank_q <= RESET_XCOLOR_VBLANK;
        end else if (ce && regWrite) begin
            if (addrSel[0]) begin
                uGainLow_q <= regWrData;
            end else if (addrSel[1]) begin
                vGainLow_q <= regWrData;
            end else if (addrSel[2]) begin
                uMsbBlack_q <= regWrData;
            end else if (addrSel[3]) begin
                vMsbBlank_q <= regWrData;
            end else if (addrSel[4]) begin
                xcolorVblank_q <= regWrData;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdData <= UNMAPPED_READ;
        end else if (ce) begin
            if (addrSel[0]) begin
                regRdData <= uGainLow_q;
            end else if (addrSel[1]) begin
                regRdData <= vGainLow_q;
            end else if (addrSel[2]) begin
                regRdData <= uMsbBlack_q;
            end else if (addrSel[3]) begin
                regRdData <= vMsbBlank_q;
            end else if (addrSel[4]) begin
                regRdData <= xcolorVblank_q;
            end else begin
                regRdData <= UNMAPPED_READ;
            end
        end
    end

    // ---------------------------------------------------------------
    // Active settings, loaded at line start
    // ---------------------------------------------------------------
    // Loading only on lineStart keeps a half-written gain pair (low byte
    // and top bit arrive in separate writes) off the visible picture.
    logic [8:0] uGainActive_q;
    logic [8:0] vGainActive_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            uGainActive_q <= join_gain(RESET_U_MSB_BLACK, RESET_U_GAIN_LOW);
            vGainActive_q <= join_gain(RESET_V_MSB_BLANK, RESET_V_GAIN_LOW);
            blackLevelCode <= RESET_U_MSB_BLACK[LEVEL_MSB:0];
            blankingLevelCode <= BLANK_LEVEL_RESET;
            verticalBlankingLevelCode <= RESET_XCOLOR_VBLANK[LEVEL_MSB:0];
            crossColorSel <= crosscolor_mode_t'(RESET_XCOLOR_VBLANK[XCOLOR_HI_BIT:XCOLOR_LO_BIT]);
        end else if (ce && lineStart) begin
            uGainActive_q <= join_gain(uMsbBlack_q, uGainLow_q);
            vGainActive_q <= join_gain(vMsbBlank_q, vGainLow_q);
            blackLevelCode <= uMsbBlack_q[LEVEL_MSB:0];
            blankingLevelCode <= vMsbBlank_q[LEVEL_MSB:0];
            verticalBlankingLevelCode <= xcolorVblank_q[LEVEL_MSB:0];
            crossColorSel <= crosscolor_mode_t'(xcolorVblank_q[XCOLOR_HI_BIT:XCOLOR_LO_BIT]);
        end
    end

    // ---------------------------------------------------------------
    // Chroma gain
    // ---------------------------------------------------------------
    // The gain is a signed code with seven fraction bits, so the nominal
    // code of each white level sets the unity point of the analog path.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            uContrib <= '0;
            vContrib <= '0;
        end else if (ce) begin
            uContrib <= scale_chroma(uChromaIn, uGainActive_q);
            vContrib <= scale_chroma(vChromaIn, vGainActive_q);
        end
    end

    // ---------------------------------------------------------------
    // Realtime control input
    // ---------------------------------------------------------------
    logic parityMeta_q;
    logic paritySync_q;
    logic phaseMeta_q;
    logic phaseSync_q;
    logic phaseSyncDly_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            parityMeta_q <= 1'b0;
            paritySync_q <= 1'b0;
            phaseMeta_q <= 1'b0;
            phaseSync_q <= 1'b0;
            phaseSyncDly_q <= 1'b0;
        end else if (ce) begin
            parityMeta_q <= realtimeFieldParity;
            paritySync_q <= parityMeta_q;
            phaseMeta_q <= realtimePhaseReset;
            phaseSync_q <= phaseMeta_q;
            phaseSyncDly_q <= phaseSync_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fieldParityOut <= 1'b0;
            subcarrierPhaseResetPulse <= 1'b0;
        end else if (ce) begin
            fieldParityOut <= uMsbBlack_q[RTC_ENABLE_BIT] & paritySync_q;
            subcarrierPhaseResetPulse <= vMsbBlank_q[RTC_ENABLE_BIT] & phaseSync_q & ~phaseSyncDly_q;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_u_zero_gain: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && uGainActive_q == 9'h000) |=> (uContrib == 10'sh000))
        else $error("U contribution not zero at zero gain");

    a_u_nominal_92: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && uGainActive_q == U_NOMINAL_92 && uChromaIn == 8'sh40) |=> (uContrib == 10'sh03b))
        else $error("U nominal gain 118 scaled wrongly");

    a_u_nominal_100: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && uGainActive_q == U_NOMINAL_100 && uChromaIn == 8'sh40) |=> (uContrib == 10'sh03e))
        else $error("U nominal gain 125 scaled wrongly");

    a_v_zero_gain: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && vGainActive_q == 9'h000) |=> (vContrib == 10'sh000))
        else $error("V contribution not zero at zero gain");

    a_v_nominal_100: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && vGainActive_q == V_NOMINAL_100 && vChromaIn == 8'sh40) |=> (vContrib == 10'sh057))
        else $error("V nominal gain 175 scaled wrongly");

    a_gain_join_load: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && lineStart) |=> (uGainActive_q == {$past(uMsbBlack_q[7]), $past(uGainLow_q)}
            && vGainActive_q == {$past(vMsbBlank_q[7]), $past(vGainLow_q)}))
        else $error("Gain not assembled from low byte and top bit");

    a_gain_hold_midline: assert property (@(posedge clk_sys) disable iff (rst)
        (!lineStart) |=> $stable(uGainActive_q) && $stable(blackLevelCode))
        else $error("Active setting changed away from line start");

    a_parity_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && !uMsbBlack_q[6]) |=> !fieldParityOut)
        else $error("Field parity passed while disabled");

    a_phase_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && vMsbBlank_q[6] && phaseSync_q && !phaseSyncDly_q) |=> subcarrierPhaseResetPulse)
        else $error("Enabled phase reset edge not forwarded");

    a_blank_reset: assert property (@(posedge clk_sys) disable iff (rst)
        $past(rst) |-> (blankingLevelCode == 6'h35))
        else $error("Blanking level not 0x35 after reset");

    a_level_load: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && lineStart) |=> (blackLevelCode == $past(uMsbBlack_q[5:0])
            && verticalBlankingLevelCode == $past(xcolorVblank_q[5:0])))
        else $error("Level code not loaded at line start");

    a_xcolor_load: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && lineStart) |=> (crossColorSel == $past(xcolorVblank_q[7:6])))
        else $error("Cross-color selection not loaded at line start");

    a_v_nominal_92: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && vGainActive_q == V_NOMINAL_92 && vChromaIn == 8'sh40) |=> (vContrib == 10'sh052))
        else $error("V nominal gain 165 scaled wrongly");

    a_blank_load: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && lineStart) |=> (blankingLevelCode == $past(vMsbBlank_q[LEVEL_MSB:0])))
        else $error("Blanking level not loaded at line start");

    a_vblank_load: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && lineStart) |=> (verticalBlankingLevelCode == $past(xcolorVblank_q[LEVEL_MSB:0])))
        else $error("Vertical blanking level not loaded at line start");

    a_xcolor_off: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && lineStart && xcolorVblank_q[XCOLOR_HI_BIT:XCOLOR_LO_BIT] == 2'b00) |=> (crossColorSel == XCOLOR_OFF))
        else $error("Cross-color reduction not disabled by code 00");

    a_xcolor_filter3: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && lineStart && xcolorVblank_q[XCOLOR_HI_BIT:XCOLOR_LO_BIT] == 2'b11) |=> (crossColorSel == XCOLOR_FILTER3))
        else $error("Cross-color filter three not selected by code 11");

    a_hold_blank_midline: assert property (@(posedge clk_sys) disable iff (rst)
        (!lineStart) |=> ($stable(vGainActive_q) && $stable(blankingLevelCode)
            && $stable(verticalBlankingLevelCode) && $stable(crossColorSel)))
        else $error("Blanking or filter setting changed away from line start");

    a_ce_freeze: assert property (@(posedge clk_sys) disable iff (rst)
        (!ce) |=> ($stable(uContrib) && $stable(vContrib) && $stable(regRdData)
            && $stable(fieldParityOut) && $stable(subcarrierPhaseResetPulse)))
        else $error("Output moved while clock enable was low");

    // ---------------------------------------------------------------
    // Register bus checks
    // ---------------------------------------------------------------

    a_u_low_write: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regWrite && regAddr == ADDR_U_GAIN_LOW) |=> (uGainLow_q == $past(regWrData)))
        else $error("U gain low byte write lost");

    a_v_low_write: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regWrite && regAddr == ADDR_V_GAIN_LOW) |=> (vGainLow_q == $past(regWrData)))
        else $error("V gain low byte write lost");

    a_u_msb_write: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regWrite && regAddr == ADDR_U_MSB_BLACK) |=> (uMsbBlack_q == $past(regWrData)))
        else $error("U top bit and black level write lost");

    a_v_msb_write: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regWrite && regAddr == ADDR_V_MSB_BLANK) |=> (vMsbBlank_q == $past(regWrData)))
        else $error("V top bit and blanking level write lost");

    a_xcolor_write: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regWrite && regAddr == ADDR_XCOLOR_VBLANK) |=> (xcolorVblank_q == $past(regWrData)))
        else $error("Cross-color and vertical blanking write lost");

    a_read_u_low: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regAddr == ADDR_U_GAIN_LOW) |=> (regRdData == $past(uGainLow_q)))
        else $error("U gain low byte read back wrongly");

    a_read_v_low: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regAddr == ADDR_V_GAIN_LOW) |=> (regRdData == $past(vGainLow_q)))
        else $error("V gain low byte read back wrongly");

    a_read_top_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regAddr == ADDR_U_MSB_BLACK) |=> (regRdData[GAIN_TOP_BIT] == $past(uMsbBlack_q[GAIN_TOP_BIT])))
        else $error("U gain top bit read back wrongly");

    a_read_blank: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regAddr == ADDR_V_MSB_BLANK) |=> (regRdData[LEVEL_MSB:0] == $past(vMsbBlank_q[LEVEL_MSB:0])))
        else $error("Blanking level read back wrongly");

    a_read_xcolor: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && regAddr == ADDR_XCOLOR_VBLANK) |=> (regRdData == $past(xcolorVblank_q)))
        else $error("Cross-color register read back wrongly");

    // ---------------------------------------------------------------
    // Realtime control checks
    // ---------------------------------------------------------------

    a_parity_pass: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && uMsbBlack_q[RTC_ENABLE_BIT] && paritySync_q) |=> fieldParityOut)
        else $error("Enabled field parity not passed");

    a_phase_block: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && !vMsbBlank_q[RTC_ENABLE_BIT]) |=> !subcarrierPhaseResetPulse)
        else $error("Phase reset passed while disabled");

    a_phase_single: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && subcarrierPhaseResetPulse) |=> !subcarrierPhaseResetPulse)
        else $error("Phase reset pulse longer than one cycle");

endmodule : video_encoder_gain_level_regs

// ### bench/i2c_host_model.sv
module i2c_host_model
    import video_gain_level_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [7:0] regRdData,
    output logic regWrite,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        regWrite = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end

    // The byte is inverted once the strobe drops, so a stale byte can never pass for fresh data.
    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        regWrite = 1'b1;
        regAddr = addr;
        regWrData = data;
        @(negedge clk_sys);
        regWrite = 1'b0;
        regWrData = ~data;
    endtask : writeReg

    task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        regAddr = addr;
        @(negedge clk_sys);
        data = regRdData;
    endtask : readReg
endmodule : i2c_host_model

// ### bench/video_encoder_gain_level_regs_tb_top.sv
module video_encoder_gain_level_regs_tb_top
    import video_gain_level_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, ce, lineStart, fpIn, prIn, regWrite;
    logic [7:0] regAddr, regWrData, regRdData, rd;
    logic signed [7:0] uIn, vIn;
    logic signed [9:0] uContrib, vContrib;
    logic [5:0] blackLevelCode, blankingLevelCode, verticalBlankingLevelCode;
    crosscolor_mode_t crossColorSel;
    logic fieldParityOut, subcarrierPhaseResetPulse;
    logic [7:0] m [0:4];
    logic [7:0] act [0:4];
    logic [7:0] lfsrState = 8'h2f;
    int fails = 0;
    int nCompared = 0;
    int n;
    int uTab [6] = '{0, 118, 125, 106, 511, 256};
    int vTab [6] = '{0, 165, 175, 129, 300, 383};

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    video_encoder_gain_level_regs DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .regWrite(regWrite),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .lineStart(lineStart),
        .realtimeFieldParity(fpIn), .realtimePhaseReset(prIn), .uChromaIn(uIn), .vChromaIn(vIn),
        .uContrib(uContrib), .vContrib(vContrib), .blackLevelCode(blackLevelCode),
        .blankingLevelCode(blankingLevelCode), .verticalBlankingLevelCode(verticalBlankingLevelCode),
        .crossColorSel(crossColorSel), .fieldParityOut(fieldParityOut),
        .subcarrierPhaseResetPulse(subcarrierPhaseResetPulse));

    i2c_host_model host (.clk_sys(clk_sys), .regRdData(regRdData), .regWrite(regWrite),
        .regAddr(regAddr), .regWrData(regWrData));

    function automatic logic [7:0] lfsrNext(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsrNext

    // Gain is a signed 9-bit code with seven fraction bits.
    function automatic logic [9:0] scaled(input logic signed [7:0] x, input int g9);
        int g;
        g = (g9 > 255) ? g9 - 512 : g9;
        return 10'((x * g) >>> 7);
    endfunction : scaled

    function automatic logic [7:0] expReg(input int a);
        return (a >= 'h5b && a <= 'h5f) ? m[a - 'h5b] : UNMAPPED_READ;
    endfunction : expReg

    task automatic cmpByte(input logic [7:0] e, input logic [7:0] a);
        nCompared++;
        if (a !== e) begin
            fails++;
            $display("Error at %0t: expected %h got %h", $time, e, a);
        end
    endtask : cmpByte

    task automatic cmpContrib(input logic [9:0] e, input logic [9:0] a);
        nCompared++;
        if (a !== e) begin
            fails++;
            $display("Error at %0t: expected %h got %h", $time, e, a);
        end
    endtask : cmpContrib

    task automatic cmpBit(input logic e, input logic a);
        nCompared++;
        if (a !== e) begin
            fails++;
            $display("Error at %0t: expected %h got %h", $time, e, a);
        end
    endtask : cmpBit

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.writeReg(a, d);
        m[a - ADDR_U_GAIN_LOW] = d;
    endtask : wr

    task automatic modelReset();
        m = '{RESET_U_GAIN_LOW, RESET_V_GAIN_LOW, RESET_U_MSB_BLACK, RESET_V_MSB_BLANK, RESET_XCOLOR_VBLANK};
        act = m;
    endtask : modelReset

    task automatic pulseLine();
        @(negedge clk_sys);
        lineStart = 1'b1;
        @(negedge clk_sys);
        lineStart = 1'b0;
        act = m;
    endtask : pulseLine

    task automatic checkLine();
        cmpByte({2'b00, act[2][5:0]}, {2'b00, blackLevelCode});
        cmpByte({2'b00, act[3][5:0]}, {2'b00, blankingLevelCode});
        cmpByte({2'b00, act[4][5:0]}, {2'b00, verticalBlankingLevelCode});
        cmpByte({6'h00, act[4][7:6]}, {6'h00, crossColorSel});
    endtask : checkLine

    task automatic checkRegs();
        for (int a = 'h5a; a <= 'h60; a++) begin
            host.readReg(8'(a), rd);
            cmpByte(expReg(a), rd);
        end
    endtask : checkRegs

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        lineStart = 1'b0;
        fpIn = 1'b0;
        prIn = 1'b0;
        uIn = '0;
        vIn = '0;
        modelReset();
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        cmpByte({2'b00, BLANK_LEVEL_RESET}, {2'b00, blankingLevelCode});
        checkLine();
        checkRegs();
        // Bit 6 is masked so the realtime enables stay off during the level sweep.
        for (int k = 0; k < 4; k++) begin
            for (int a = 0; a < 5; a++) begin
                lfsrState = lfsrNext(lfsrState);
                wr(8'(a + 'h5b), (a == 4) ? {2'(k), lfsrState[5:0]} : (lfsrState & 8'hbf));
            end
            checkLine();
            pulseLine();
            checkLine();
        end
        for (int j = 0; j < 6; j++) begin
            wr(ADDR_U_GAIN_LOW, 8'(uTab[j]));
            wr(ADDR_V_GAIN_LOW, 8'(vTab[j]));
            wr(ADDR_U_MSB_BLACK, {uTab[j] > 255, 7'h33});
            wr(ADDR_V_MSB_BLANK, {vTab[j] > 255, 7'h35});
            pulseLine();
            for (int s = 0; s < 4; s++) begin
                // The first beat is mid-scale so the nominal-gain checks in the design see their trigger.
                lfsrState = lfsrNext(lfsrState);
                uIn = (s == 0) ? 8'h40 : lfsrState;
                lfsrState = lfsrNext(lfsrState);
                vIn = (s == 0) ? 8'h40 : lfsrState;
                @(negedge clk_sys);
                cmpContrib(scaled(uIn, uTab[j]), uContrib);
                cmpContrib(scaled(vIn, vTab[j]), vContrib);
            end
        end
        ce = 1'b0;
        host.writeReg(ADDR_V_GAIN_LOW, 8'h00);
        ce = 1'b1;
        checkRegs();
        fpIn = 1'b1;
        repeat (4) @(negedge clk_sys);
        cmpBit(1'b0, fieldParityOut);
        wr(ADDR_U_MSB_BLACK, 8'h73);
        repeat (4) @(negedge clk_sys);
        cmpBit(1'b1, fieldParityOut);
        fpIn = 1'b0;
        repeat (4) @(negedge clk_sys);
        cmpBit(1'b0, fieldParityOut);
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_V_MSB_BLANK, (e == 0) ? 8'h75 : 8'h35);
            prIn = 1'b1;
            n = 0;
            for (int i = 0; i < 8; i++) begin
                @(negedge clk_sys);
                n += int'(subcarrierPhaseResetPulse === 1'b1);
            end
            cmpByte(8'(1 - e), 8'(n));
            prIn = 1'b0;
            repeat (4) @(negedge clk_sys);
        end
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        modelReset();
        checkLine();
        checkRegs();
        wrap_up();
    end

    initial begin
        #100us;
        fails++;
        wrap_up();
    end
endmodule : video_encoder_gain_level_regs_tb_top
